// >>> wfch_pkg.sv
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`default_nettype none
package wfch_pkg;
    localparam int OCT_W = 8;
    localparam int CRC_W = 16;
    localparam int DLCI_W = 13;
    localparam int CODING_W = 5;
    localparam int ORDER_W = 4;
    localparam int DROP_W = 2;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int EV_W = 3;
    // check sequence
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY_REV = 16'h8408;
    localparam logic [15:0] CRC_GOOD = 16'hf0b8;
    // octet positions, counted from 1 without flags
    localparam logic [3:0] POS_ADDR1 = 4'h1;
    localparam logic [3:0] POS_ADDR2 = 4'h2;
    localparam logic [3:0] POS_PROTO = 4'h4;
    localparam logic [3:0] POS_CODING = 4'h5;
    localparam logic [3:0] POS_ORDER = 4'h6;
    localparam logic [3:0] POS_STAMP = 4'h7;
    localparam logic [3:0] HDR_CHECK_LEN = 4'h8;
    localparam logic [3:0] MIN_LEN = 4'ha;
    // field positions inside header octets
    localparam int MORE_BIT = 7;
    localparam int CODING_LSB = 0;
    localparam int ORDER_LSB = 4;
    localparam int DROPPED_LSB = 2;
    localparam int MAXDROP_LSB = 0;
    // protocol selector codes carrying voice or voiceband data
    localparam logic [7:0] PROTO_VOICE = 8'h01;
    localparam logic [7:0] PROTO_VBD = 8'h02;
    // register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_MASK = 4'h2;
    localparam logic [3:0] REG_HDR = 4'h3;
    localparam logic [3:0] REG_LINK = 4'h4;
    localparam logic [3:0] REG_ORDER_STAMP = 4'h5;
    localparam logic [3:0] REG_DROP = 4'h6;
    localparam logic [3:0] REG_FRAMES = 4'h7;
    // field and event bits
    localparam int CTRL_CONGEST = 0;
    localparam int EV_OK = 0;
    localparam int EV_CRC = 1;
    localparam int EV_ORDER = 2;
    // reset values
    localparam logic CTRL_RST = 1'b0;
    localparam logic [2:0] MASK_RST = 3'h0;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_TICK_NS = 1000000;
    localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
    typedef enum logic [0:0] {
        WFCH_IDLE = 1'b0,
        WFCH_FRAME = 1'b1
    } wfch_fsm_t;
endpackage
`default_nettype wire

// >>> wfch_crc16.sv
`default_nettype none
module wfch_crc16 (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // octet feed
    input wire logic init_in,
    input wire logic en_in,
    input wire logic [wfch_pkg::OCT_W-1:0] data_in,
    // running check value
    output logic [wfch_pkg::CRC_W-1:0] crc_out
);
    typedef struct packed {
        logic [wfch_pkg::CRC_W-1:0] crc;
    } wfch_crc_state_t;

    wfch_crc_state_t r_reg;
    wfch_crc_state_t r_next;

    // one octet, low bit first, reflected polynomial
    function automatic logic [15:0] wfch_crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c;
        for (int i = 0; i < 8; i++) begin
            x = (x[0] ^ d[i]) ? ((x >> 1) ^ wfch_pkg::CRC_POLY_REV) : (x >> 1);
        end
        return x;
    endfunction

    always_comb begin
        r_next = r_reg;
        if (en_in) begin
            r_next.crc = wfch_crc_byte(init_in ? wfch_pkg::CRC_INIT : r_reg.crc, data_in);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            r_reg <= '{crc: wfch_pkg::CRC_INIT};
        end else begin
            r_reg <= r_next;
        end
    end

    assign crc_out = r_reg.crc;

    property p_crc_zero_octet;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        en_in && init_in && data_in == 8'h00 |=> crc_out == 16'h0f87;
    endproperty
    a_crc_zero_octet: assert property (p_crc_zero_octet) else $error("check step wrong");

    property p_crc_hold;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        !en_in |=> $stable(crc_out);
    endproperty
    a_crc_hold: assert property (p_crc_hold) else $error("check moved without octet");
endmodule
`default_nettype wire

// >>> wfch_rx_checker.sv
// The address-and-strobe port and the register addresses are this design's own decisions.
`default_nettype none
module wfch_rx_checker #(
    parameter int unsigned MS_TICK_CYCLES = wfch_pkg::MS_TICK_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // frame octet stream
    input wire logic rx_valid_in,
    input wire logic [wfch_pkg::OCT_W-1:0] rx_data_in,
    input wire logic rx_first_in,
    input wire logic rx_last_in,
    input wire logic rx_header_only_check_in,
    // register port
    input wire logic [wfch_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [wfch_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [wfch_pkg::DATA_W-1:0] reg_rdata_out,
    output logic irq_out,
    // extracted header
    output logic hdr_valid_out,
    output logic frame_err_out,
    output logic [7:0] protocol_selector_out,
    output logic is_voice_out,
    output logic [wfch_pkg::CODING_W-1:0] coding_method_field_out,
    output logic [wfch_pkg::DLCI_W-1:0] link_id_out,
    output logic [wfch_pkg::DROP_W-1:0] dropped_block_count_out,
    output logic [wfch_pkg::DROP_W-1:0] max_drop_count_out,
    output logic [wfch_pkg::DROP_W-1:0] droppable_blocks_out,
    output logic more_packets_out,
    output logic [wfch_pkg::ORDER_W-1:0] packet_order_number_out,
    output logic [7:0] queuing_delay_stamp_out
);
    localparam int MS_W = $clog2(MS_TICK_CYCLES);
    localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_TICK_CYCLES - 1);

    if (MS_TICK_CYCLES < 2) begin : g_bad_tick
        $error("MS_TICK_CYCLES must be at least 2");
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        wfch_pkg::wfch_fsm_t fsm;
        logic [3:0] idx;
        logic uih;
        logic chk;
        logic [7:0] fcs_lo;
        logic [7:0] fcs_hi;
        logic [12:0] dlci_s;
        logic [7:0] proto_s;
        logic [7:0] oct5_s;
        logic [7:0] oct6_s;
        logic [7:0] stamp_s;
        logic [MS_W-1:0] ms_cnt;
        logic [7:0] elapsed;
        logic congest;
        logic [2:0] status;
        logic [2:0] mask;
        logic [3:0] order_exp;
        logic order_seen;
        logic [7:0] frames;
        logic [15:0] rdata;
        logic irq;
        logic hdr_valid;
        logic frame_err;
        logic [7:0] proto;
        logic voice;
        logic [4:0] coding;
        logic [12:0] dlci;
        logic [1:0] dropped;
        logic [1:0] maxd;
        logic [1:0] droppable;
        logic more;
        logic [3:0] order;
        logic [7:0] stamp;
    } wfch_top_state_t;

    wfch_top_state_t r_reg;
    wfch_top_state_t r_next;
    logic crc_init;
    logic crc_en;
    logic [15:0] crc_val;

    function automatic logic wfch_is_voice(input logic [7:0] p);
        return (p == wfch_pkg::PROTO_VOICE) || (p == wfch_pkg::PROTO_VBD);
    endfunction

    function automatic logic [3:0] wfch_sat_inc(input logic [3:0] v);
        return (v == 4'hf) ? v : v + 4'h1;
    endfunction

    wfch_crc16 wfch_crc16_i (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .init_in(crc_init),
        .en_in(crc_en),
        .data_in(rx_data_in),
        .crc_out(crc_val)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic tick;
        logic good;
        logic uih_now;
        logic [3:0] pos;
        logic [2:0] ev;
        logic [2:0] clr;
        logic [8:0] sum;
        r_next = r_reg;
        tick = (r_reg.ms_cnt == MS_LAST);
        good = 1'b0;
        uih_now = 1'b0;
        pos = 4'h0;
        ev = 3'h0;
        clr = 3'h0;
        sum = 9'h000;
        crc_init = 1'b0;
        crc_en = 1'b0;
        r_next.hdr_valid = 1'b0;
        r_next.frame_err = 1'b0;
        r_next.chk = 1'b0;
        r_next.rdata = 16'h0000;

        // 1 ms enable and residence time of the frame
        r_next.ms_cnt = tick ? '0 : r_reg.ms_cnt + 1'b1;
        if (r_reg.fsm == wfch_pkg::WFCH_FRAME && tick && r_reg.elapsed != 8'hff) begin
            r_next.elapsed = r_reg.elapsed + 8'h01;
        end

        // octet intake
        if (rx_valid_in && (rx_first_in || r_reg.fsm == wfch_pkg::WFCH_FRAME)) begin
            pos = rx_first_in ? 4'h1 : wfch_sat_inc(r_reg.idx);
            uih_now = rx_first_in ? rx_header_only_check_in : r_reg.uih;
            r_next.idx = pos;
            if (rx_first_in) begin
                r_next.uih = rx_header_only_check_in;
                r_next.elapsed = 8'h00;
            end
            crc_init = rx_first_in;
            crc_en = !uih_now || pos <= wfch_pkg::HDR_CHECK_LEN;
            r_next.fcs_lo = r_reg.fcs_hi;
            r_next.fcs_hi = rx_data_in;
            case (pos)
                wfch_pkg::POS_ADDR1: r_next.dlci_s[12:7] = rx_data_in[7:2];
                wfch_pkg::POS_ADDR2: r_next.dlci_s[6:0] = rx_data_in[7:1];
                wfch_pkg::POS_PROTO: r_next.proto_s = rx_data_in;
                wfch_pkg::POS_CODING: r_next.oct5_s = rx_data_in;
                wfch_pkg::POS_ORDER: r_next.oct6_s = rx_data_in;
                wfch_pkg::POS_STAMP: r_next.stamp_s = rx_data_in;
                default: ;
            endcase
            r_next.fsm = rx_last_in ? wfch_pkg::WFCH_IDLE : wfch_pkg::WFCH_FRAME;
            r_next.chk = rx_last_in;
        end

        // verdict one cycle after the closing octet
        if (r_reg.chk) begin
            good = (r_reg.idx >= wfch_pkg::MIN_LEN) &&
                (r_reg.uih ? (~crc_val == {r_reg.fcs_hi, r_reg.fcs_lo})
                           : (crc_val == wfch_pkg::CRC_GOOD));
            if (good) begin
                r_next.hdr_valid = 1'b1;
                r_next.proto = r_reg.proto_s;
                r_next.voice = wfch_is_voice(r_reg.proto_s);
                r_next.coding = r_next.voice ?
                    r_reg.oct5_s[wfch_pkg::CODING_LSB +: wfch_pkg::CODING_W] : 5'h00;
                r_next.dropped = r_next.voice ?
                    r_reg.oct6_s[wfch_pkg::DROPPED_LSB +: wfch_pkg::DROP_W] : 2'h0;
                r_next.maxd = r_next.voice ?
                    r_reg.oct6_s[wfch_pkg::MAXDROP_LSB +: wfch_pkg::DROP_W] : 2'h0;
                r_next.more = r_reg.oct5_s[wfch_pkg::MORE_BIT];
                r_next.order = r_reg.oct6_s[wfch_pkg::ORDER_LSB +: wfch_pkg::ORDER_W];
                r_next.dlci = r_reg.dlci_s;
                sum = {1'b0, r_reg.stamp_s} + {1'b0, r_reg.elapsed};
                r_next.stamp = sum[8] ? 8'hff : sum[7:0];
                if (r_reg.order_seen && r_next.order != r_reg.order_exp) begin
                    ev[wfch_pkg::EV_ORDER] = 1'b1;
                end
                r_next.order_exp = r_next.order + 4'h1;
                r_next.order_seen = 1'b1;
                r_next.frames = r_reg.frames + 8'h01;
                ev[wfch_pkg::EV_OK] = 1'b1;
            end else begin
                r_next.frame_err = 1'b1;
                ev[wfch_pkg::EV_CRC] = 1'b1;
            end
        end

        // register writes
        if (reg_wr_in) begin
            case (reg_addr_in)
                wfch_pkg::REG_CTRL: r_next.congest = reg_wdata_in[wfch_pkg::CTRL_CONGEST];
                wfch_pkg::REG_STATUS: clr = reg_wdata_in[2:0];
                wfch_pkg::REG_MASK: r_next.mask = reg_wdata_in[2:0];
                default: ;
            endcase
        end
        // new events win over a clear in the same cycle
        r_next.status = (r_reg.status & ~clr) | ev;
        r_next.irq = |(r_next.status & r_next.mask);

        // whole blocks may go only while congestion relief is on
        r_next.droppable = (r_next.congest && r_next.voice && r_next.maxd > r_next.dropped) ?
            r_next.maxd - r_next.dropped : 2'h0;

        // register reads, data valid in the following cycle only
        if (reg_rd_in) begin
            case (reg_addr_in)
                wfch_pkg::REG_CTRL: r_next.rdata = {15'h0000, r_reg.congest};
                wfch_pkg::REG_STATUS: r_next.rdata = {13'h0000, r_reg.status};
                wfch_pkg::REG_MASK: r_next.rdata = {13'h0000, r_reg.mask};
                wfch_pkg::REG_HDR: r_next.rdata = {r_reg.proto, r_reg.voice, 2'h0, r_reg.coding};
                wfch_pkg::REG_LINK: r_next.rdata = {3'h0, r_reg.dlci};
                wfch_pkg::REG_ORDER_STAMP: r_next.rdata =
                    {r_reg.stamp, r_reg.order, r_reg.more, 3'h0};
                wfch_pkg::REG_DROP: r_next.rdata =
                    {10'h000, r_reg.droppable, r_reg.maxd, r_reg.dropped};
                wfch_pkg::REG_FRAMES: r_next.rdata = {8'h00, r_reg.frames};
                default: r_next.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            r_reg <= '0;
            r_reg.fsm <= wfch_pkg::WFCH_IDLE;
            r_reg.congest <= wfch_pkg::CTRL_RST;
            r_reg.mask <= wfch_pkg::MASK_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign reg_rdata_out = r_reg.rdata;
    assign irq_out = r_reg.irq;
    assign hdr_valid_out = r_reg.hdr_valid;
    assign frame_err_out = r_reg.frame_err;
    assign protocol_selector_out = r_reg.proto;
    assign is_voice_out = r_reg.voice;
    assign coding_method_field_out = r_reg.coding;
    assign link_id_out = r_reg.dlci;
    assign dropped_block_count_out = r_reg.dropped;
    assign max_drop_count_out = r_reg.maxd;
    assign droppable_blocks_out = r_reg.droppable;
    assign more_packets_out = r_reg.more;
    assign packet_order_number_out = r_reg.order;
    assign queuing_delay_stamp_out = r_reg.stamp;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_last_octet;
        rx_valid_in && rx_last_in && (rx_first_in || r_reg.fsm == wfch_pkg::WFCH_FRAME);
    endsequence
    sequence s_verdict;
        hdr_valid_out ^ frame_err_out;
    endsequence
    sequence s_fourth_octet;
        rx_valid_in && !rx_first_in && r_reg.fsm == wfch_pkg::WFCH_FRAME && r_reg.idx == 4'h3;
    endsequence

    property p_verdict;
        s_last_octet |=> ##1 s_verdict;
    endproperty
    a_verdict: assert property (p_verdict) else $error("no verdict two cycles after frame");

    property p_uih_frozen;
        rx_valid_in && !rx_first_in && r_reg.fsm == wfch_pkg::WFCH_FRAME && r_reg.uih &&
            r_reg.idx >= wfch_pkg::HDR_CHECK_LEN |=> $stable(crc_val);
    endproperty
    a_uih_frozen: assert property (p_uih_frozen) else $error("payload entered header check");

    property p_ui_all;
        rx_valid_in && r_reg.fsm == wfch_pkg::WFCH_FRAME && !rx_first_in && !r_reg.uih
            |-> crc_en;
    endproperty
    a_ui_all: assert property (p_ui_all) else $error("octet skipped in full check");

    property p_hdr_pos;
        s_fourth_octet |=> r_reg.proto_s == $past(rx_data_in);
    endproperty
    a_hdr_pos: assert property (p_hdr_pos) else $error("selector not from octet 4");

    property p_proto;
        hdr_valid_out |-> protocol_selector_out == $past(r_reg.proto_s) &&
            is_voice_out == wfch_is_voice(protocol_selector_out);
    endproperty
    a_proto: assert property (p_proto) else $error("protocol selection wrong");

    property p_coding;
        hdr_valid_out |-> coding_method_field_out ==
            (is_voice_out ? $past(r_reg.oct5_s[4:0]) : 5'h00);
    endproperty
    a_coding: assert property (p_coding) else $error("coding method wrong");

    property p_link;
        hdr_valid_out |-> link_id_out == $past(r_reg.dlci_s);
    endproperty
    a_link: assert property (p_link) else $error("link identifier wrong");

    property p_drop;
        hdr_valid_out && is_voice_out |-> dropped_block_count_out == $past(r_reg.oct6_s[3:2]) &&
            max_drop_count_out == $past(r_reg.oct6_s[1:0]);
    endproperty
    a_drop: assert property (p_drop) else $error("block dropping field wrong");

    property p_droppable;
        droppable_blocks_out != 2'h0 |-> r_reg.congest &&
            droppable_blocks_out == max_drop_count_out - dropped_block_count_out;
    endproperty
    a_droppable: assert property (p_droppable) else $error("droppable blocks wrong");

    property p_more;
        hdr_valid_out |-> more_packets_out == $past(r_reg.oct5_s[7]);
    endproperty
    a_more: assert property (p_more) else $error("more flag wrong");

    property p_order;
        hdr_valid_out && $past(r_reg.order_seen) &&
            packet_order_number_out != $past(r_reg.order_exp)
            |-> r_reg.status[wfch_pkg::EV_ORDER];
    endproperty
    a_order: assert property (p_order) else $error("order gap not flagged");

    property p_stamp;
        hdr_valid_out |-> queuing_delay_stamp_out >= $past(r_reg.stamp_s);
    endproperty
    a_stamp: assert property (p_stamp) else $error("delay stamp decreased");

    property p_err_keep;
        frame_err_out |-> !hdr_valid_out && $stable(link_id_out) && $stable(protocol_selector_out);
    endproperty
    a_err_keep: assert property (p_err_keep) else $error("bad frame delivered fields");
endmodule
`default_nettype wire

// >>> wfch_peer_model.sv
`default_nettype none
module wfch_peer_model (
    // clock
    input wire logic sys_clk_in,
    // octet stream towards the receiver
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    output logic rx_first_out,
    output logic rx_last_out,
    output logic rx_hoc_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] fr [0:15];
    initial begin
        rx_valid_out = 1'b0;
        rx_data_out = 8'h00;
        rx_first_out = 1'b0;
        rx_last_out = 1'b0;
        rx_hoc_out = 1'b0;
    end
    // ---------------------------------------------------------------
    // one frame: n octets, then the check low octet first
    // ---------------------------------------------------------------
    task automatic send(input int n, input logic hoc, input logic bad);
        logic [15:0] c;
        logic [7:0] o;
        c = wfch_pkg::CRC_INIT;
        for (int i = 0; i < (hoc ? 8 : n); i++) begin
            for (int b = 0; b < 8; b++) begin
                c = (c[0] ^ fr[i][b]) ? (c >> 1) ^ wfch_pkg::CRC_POLY_REV : c >> 1;
            end
        end
        c = ~c ^ {15'h0000, bad};
        for (int i = 0; i < n + 2; i++) begin
            o = (i < n) ? fr[i] : ((i == n) ? c[7:0] : c[15:8]);
            @(posedge sys_clk_in);
            rx_valid_out <= 1'b1;
            rx_data_out <= o;
            rx_first_out <= (i == 0);
            rx_last_out <= (i == n + 1);
            rx_hoc_out <= hoc;
        end
        @(posedge sys_clk_in);
        rx_valid_out <= 1'b0;
        rx_first_out <= 1'b0;
        rx_last_out <= 1'b0;
        // released line does not keep the last octet
        rx_data_out <= ~o;
    endtask
endmodule
`default_nettype wire

// >>> wideband_frame_check_header_tb_top.sv
`default_nettype none
module wideband_frame_check_header_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // wiring
    // ---------------------------------------------------------------
    logic sys_clk_in, sys_rst_in, rx_valid, rx_first, rx_last, rx_hoc;
    logic reg_wr, reg_rd, irq, hdr_valid, frame_err, voice, more;
    logic [7:0] rx_data, sel, stamp;
    logic [3:0] reg_addr, order, ord;
    logic [15:0] reg_wdata, reg_rdata;
    logic [4:0] coding;
    logic [12:0] link;
    logic [1:0] dropped, maxd, dropable;
    int n_fail, tests_run;
    wfch_peer_model wfch_peer_model_i (.sys_clk_in(sys_clk_in),
        .rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_first_out(rx_first),
        .rx_last_out(rx_last), .rx_hoc_out(rx_hoc));
    // 13-cycle millisecond: a 14-octet frame spans exactly one tick
    wfch_rx_checker #(.MS_TICK_CYCLES(13)) wfch_rx_checker_i (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .rx_valid_in(rx_valid),
        .rx_data_in(rx_data), .rx_first_in(rx_first), .rx_last_in(rx_last),
        .rx_header_only_check_in(rx_hoc), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .irq_out(irq), .hdr_valid_out(hdr_valid),
        .frame_err_out(frame_err), .protocol_selector_out(sel), .is_voice_out(voice),
        .coding_method_field_out(coding), .link_id_out(link),
        .dropped_block_count_out(dropped), .max_drop_count_out(maxd),
        .droppable_blocks_out(dropable), .more_packets_out(more),
        .packet_order_number_out(order), .queuing_delay_stamp_out(stamp));
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    // frame with header octet 6 = {ord, lo}; waits for the verdict pulse
    task automatic frame(input logic [7:0] s, input logic [3:0] lo, input int n,
                         input logic hoc, input logic bad, input logic ok);
        int w;
        for (int i = 0; i < 16; i++) begin
            wfch_peer_model_i.fr[i] = 8'(8'h40 + i);
        end
        wfch_peer_model_i.fr[0] = 8'hb4;
        wfch_peer_model_i.fr[1] = 8'h6e;
        wfch_peer_model_i.fr[3] = s;
        wfch_peer_model_i.fr[4] = 8'h93;
        wfch_peer_model_i.fr[5] = {ord, lo};
        wfch_peer_model_i.fr[6] = 8'h21;
        wfch_peer_model_i.send(n, hoc, bad);
        w = 0;
        while (hdr_valid !== 1'b1 && frame_err !== 1'b1 && w < 8) begin
            @(posedge sys_clk_in);
            #1;
            w++;
        end
        chk(16'({hdr_valid, frame_err}), ok ? 16'h0002 : 16'h0001);
        if (ok) begin
            ord = ord + 4'h1;
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        n_fail++;
        conclude;
    end
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        n_fail = 0;
        tests_run = 0;
        ord = 4'h3;
        sys_rst_in = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (10) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        wr(4'hf, 16'hffff);
        rd(wfch_pkg::REG_CTRL, 16'h0000);
        rd(wfch_pkg::REG_MASK, 16'h0000);
        rd(wfch_pkg::REG_STATUS, 16'h0000);
        rd(4'hf, 16'h0000);
        chk(16'({irq, sel}), 16'h0000);
        $display("test reset done");
        for (int k = 1; k <= 3; k++) begin
            frame(8'(k), 4'hb, 12, 1'b0, 1'b0, 1'b1);
            chk(16'({sel, voice}), 16'({8'(k), k < 3}));
            chk(16'({coding, dropped, maxd}), (k < 3) ? 16'h013b : 16'h0000);
            chk(16'(link), 16'h16b7);
            chk(16'({more, order, stamp}), 16'({1'b1, 4'(ord - 4'h1), 8'h22}));
        end
        rd(wfch_pkg::REG_FRAMES, 16'h0003);
        rd(wfch_pkg::REG_STATUS, 16'h0001);
        chk(16'(irq), 16'h0000);
        $display("test full check done");
        frame(8'h01, 4'hb, 14, 1'b1, 1'b0, 1'b1);
        $display("test header check done");
        wr(wfch_pkg::REG_MASK, 16'h0002);
        frame(8'h03, 4'hb, 12, 1'b0, 1'b1, 1'b0);
        chk(16'({sel, irq}), 16'h0003);
        rd(wfch_pkg::REG_STATUS, 16'h0003);
        wr(wfch_pkg::REG_STATUS, 16'h0003);
        chk(16'(irq), 16'h0000);
        frame(8'h01, 4'hb, 12, 1'b0, 1'b0, 1'b1);
        frame(8'h01, 4'hb, 6, 1'b0, 1'b0, 1'b0);
        rd(wfch_pkg::REG_STATUS, 16'h0003);
        wr(wfch_pkg::REG_STATUS, 16'h0007);
        $display("test error done");
        wr(wfch_pkg::REG_CTRL, 16'h0001);
        frame(8'h02, 4'h7, 12, 1'b0, 1'b0, 1'b1);
        chk(16'(dropable), 16'h0002);
        rd(wfch_pkg::REG_DROP, 16'h002d);
        rd(wfch_pkg::REG_HDR, 16'h0293);
        rd(wfch_pkg::REG_LINK, 16'h16b7);
        rd(wfch_pkg::REG_ORDER_STAMP, 16'({8'h22, 4'(ord - 4'h1), 4'h8}));
        wr(wfch_pkg::REG_CTRL, 16'h0000);
        rd(wfch_pkg::REG_DROP, 16'h000d);
        $display("test congestion done");
        wr(wfch_pkg::REG_MASK, 16'h0004);
        ord = ord + 4'h1;
        frame(8'h01, 4'hb, 12, 1'b0, 1'b0, 1'b1);
        chk(16'(irq), 16'h0001);
        rd(wfch_pkg::REG_STATUS, 16'h0005);
        $display("test order done");
        conclude;
    end
endmodule
`default_nettype wire
